// >>> common/irq_unit_cfg.svh
// constants for the vectored interrupt priority unit
// assumes inclusion by the top module only
`ifndef IRQ_UNIT_CFG_SVH
`define IRQ_UNIT_CFG_SVH

// register word addresses on the plain port
`define ADDR_PRIO_A 4'h0
`define ADDR_PRIO_B 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_MASK 4'h3
`define ADDR_CTRL 4'h4
`define ADDR_VECTOR 4'h5
`define ADDR_BASE_LO 4'h6

// priority field positions and reset level
`define TIMER_ONE_LSB 12
`define COMPARE_ONE_LSB 8
`define CAPTURE_ONE_LSB 4
`define EXT_ZERO_LSB 0
`define PRIO_RESET_LEVEL 3'h4
`define PRIO_A_RESET 16'h4444
`define PRIO_A_WMASK 16'h7777

// vector tables
`define PRIMARY_BASE 24'h000014
`define ALTERNATE_BASE 24'h000114
`define VECTOR_OFFSET 8'h08

// request numbers
`define REQ_EXT_ZERO 7'h00
`define REQ_CAPTURE_ONE 7'h01
`define REQ_COMPARE_ONE 7'h02
`define REQ_TIMER_ONE 7'h03
`define REQ_RESERVED_FOUR 7'h04
`define REQ_CAPTURE_TWO 7'h05
`define REQ_COMPARE_TWO 7'h06
`define REQ_TIMER_TWO 7'h07
`define REQ_TIMER_THREE 7'h08
`define REQ_SPI_FAULT 7'h09
`define REQ_SPI_DONE 7'h0a
`define REQ_ASYNC_RX 7'h0b
`define REQ_ASYNC_TX 7'h0c
`define REQ_CONV_GROUP 7'h0d
`define REQ_TWOWIRE_SLAVE 7'h10
`define REQ_TWOWIRE_MASTER 7'h11
`define REQ_COMPARATOR_ONE 7'h12
`define REQ_CHANGE_NOTIFY 7'h13
`define REQ_EXT_ONE 7'h14
`define REQ_EXT_TWO 7'h1d
`define REQ_SPECIAL_MATCH 7'h39
`define REQ_ASYNC_ERR 7'h41
`define REQ_PWM_FIRST 7'h5e
`define REQ_COMPARATOR_TWO 7'h67
`define REQ_PAIR_FIRST 7'h6e

`endif

// >>> common/irq_unit_pkg.sv
// types shared by the vectored interrupt priority unit
// assumes nothing beyond a standard compiler
package irq_unit_pkg;
	typedef logic [2:0] level_t;
	typedef logic [6:0] req_num_t;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_present = 2'b01,
		st_wait_ack = 2'b11
	} deliver_state_t;
endpackage

// >>> design/irq_arbiter.sv
// combinational arbiter over all request numbers
// assumes levels already zeroed for disabled or idle requests
`timescale 1ns/1ps
module irq_arbiter
	import irq_unit_pkg::*;
#(
	parameter int NUM_REQ = 118
) (
	input wire logic [NUM_REQ*3-1:0] i_levels,
	output logic o_found,
	output req_num_t o_req,
	output level_t o_level
);

	// strict greater keeps the lower number on ties
	always_comb begin
		o_found = 1'b0;
		o_req = 7'h00;
		o_level = 3'h0;
		for (int n = 0; n < NUM_REQ; n++) begin
			if (i_levels[n*3 +: 3] > o_level) begin
				o_found = 1'b1;
				o_req = req_num_t'(n);
				o_level = i_levels[n*3 +: 3];
			end
		end
	end
endmodule // irq_arbiter

// >>> design/vectored_interrupt_priority_unit.sv
// Function
// - three-bit level, 111 highest, 001 lowest
// - level zero never presented to core
// - lower request number wins natural order
// - vector addresses base plus twice number
// - external irqs map to 0, 20, 29
// - capture/compare map to 1, 2, 5, 6
// - timers 3, 7, 8; request 4 reserved
// - serial fault 9, transfer done 10
// - async rx 11, tx 12, error 65
// - converter group 13, pairs 110 to 116
// - two-wire slave 16, master 17
// - comparators 18, 103, 104, 105
// - change notification is request 19
// - special match 57, pwm 94 to 97
// - unimplemented bits ignore writes, read zero
//
// top of the vectored interrupt unit: latches peripheral requests,
// arbitrates, presents a vector to the core until acknowledged.
// assumes request inputs synchronous to i_clk_sys, one-cycle ack.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "irq_unit_cfg.svh"
module vectored_interrupt_priority_unit
	import irq_unit_pkg::*;
#(
	parameter int NUM_REQ = 118,
	parameter level_t OTHER_LEVEL_RESET = 3'h4
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic i_ext_irq_zero,
	input wire logic i_ext_irq_one,
	input wire logic i_ext_irq_two,
	input wire logic i_capture_one,
	input wire logic i_capture_two,
	input wire logic i_compare_one,
	input wire logic i_compare_two,
	input wire logic i_timer_one_event,
	input wire logic i_timer_two_event,
	input wire logic i_timer_three_event,
	input wire logic i_serial_periph_fault,
	input wire logic i_serial_periph_done,
	input wire logic i_async_receive_event,
	input wire logic i_async_transmit_event,
	input wire logic i_async_error_event,
	input wire logic i_conv_group_done,
	input wire logic [6:0] i_conv_pair_done,
	input wire logic i_twowire_slave_event,
	input wire logic i_twowire_master_event,
	input wire logic [3:0] i_comparator_event,
	input wire logic i_change_notify_event,
	input wire logic i_special_event_match,
	input wire logic [3:0] i_pwm_event,
	input wire logic i_alt_table_sel,
	input wire logic i_vector_ack,
	output logic o_vector_valid,
	output logic [23:0] o_vector_addr,
	output logic [7:0] o_vector_num,
	output logic [2:0] o_vector_level,
	output logic o_irq
);

	////////////////////////////////////////////////////////////////
	// request vector by number

	logic [NUM_REQ-1:0] raw_req;

	always_comb begin
		raw_req = '0;
		raw_req[`REQ_EXT_ZERO] = i_ext_irq_zero;
		raw_req[`REQ_EXT_ONE] = i_ext_irq_one;
		raw_req[`REQ_EXT_TWO] = i_ext_irq_two;
		raw_req[`REQ_CAPTURE_ONE] = i_capture_one;
		raw_req[`REQ_COMPARE_ONE] = i_compare_one;
		raw_req[`REQ_CAPTURE_TWO] = i_capture_two;
		raw_req[`REQ_COMPARE_TWO] = i_compare_two;
		raw_req[`REQ_TIMER_ONE] = i_timer_one_event;
		raw_req[`REQ_TIMER_TWO] = i_timer_two_event;
		raw_req[`REQ_TIMER_THREE] = i_timer_three_event;
		raw_req[`REQ_RESERVED_FOUR] = 1'b0;
		raw_req[`REQ_SPI_FAULT] = i_serial_periph_fault;
		raw_req[`REQ_SPI_DONE] = i_serial_periph_done;
		raw_req[`REQ_ASYNC_RX] = i_async_receive_event;
		raw_req[`REQ_ASYNC_TX] = i_async_transmit_event;
		raw_req[`REQ_ASYNC_ERR] = i_async_error_event;
		raw_req[`REQ_CONV_GROUP] = i_conv_group_done;
		for (int p = 0; p < 7; p++) begin
			raw_req[`REQ_PAIR_FIRST + p] = i_conv_pair_done[p];
		end
		raw_req[`REQ_TWOWIRE_SLAVE] = i_twowire_slave_event;
		raw_req[`REQ_TWOWIRE_MASTER] = i_twowire_master_event;
		raw_req[`REQ_COMPARATOR_ONE] = i_comparator_event[0];
		for (int c = 0; c < 3; c++) begin
			raw_req[`REQ_COMPARATOR_TWO + c] = i_comparator_event[c+1];
		end
		raw_req[`REQ_CHANGE_NOTIFY] = i_change_notify_event;
		raw_req[`REQ_SPECIAL_MATCH] = i_special_event_match;
		for (int w = 0; w < 4; w++) begin
			raw_req[`REQ_PWM_FIRST + w] = i_pwm_event[w];
		end
	end

	////////////////////////////////////////////////////////////////
	// registers

	logic [15:0] priority_control_a;
	logic [15:0] prio_b;
	logic [NUM_REQ-1:0] pending;
	logic [NUM_REQ-1:0] ack_clear;
	logic [15:0] status;
	logic [15:0] mask;
	logic enable;
	deliver_state_t state;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			priority_control_a <= `PRIO_A_RESET;
		end else if (i_wr && i_addr == `ADDR_PRIO_A) begin
			priority_control_a <= i_wdata & `PRIO_A_WMASK;
		end
	end

	// one shared level for every other source, kept small on purpose
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			prio_b <= {13'h0000, OTHER_LEVEL_RESET};
		end else if (i_wr && i_addr == `ADDR_PRIO_B) begin
			prio_b <= {13'h0000, i_wdata[2:0]};
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			mask <= 16'h0000;
			enable <= 1'b1;
		end else if (i_wr && i_addr == `ADDR_MASK) begin
			mask <= i_wdata & 16'h0003;
		end else if (i_wr && i_addr == `ADDR_CTRL) begin
			enable <= i_wdata[0];
		end
	end

	// pending latches requests in every cycle they are high; set beats the ack clear
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			pending <= '0;
		end else begin
			pending <= (pending & ~ack_clear) | raw_req;
		end
	end

	////////////////////////////////////////////////////////////////
	// per-request level

	function automatic level_t level_of(input int n,
			input logic [15:0] pa, input logic [15:0] pb);
		level_t lv;
		lv = pb[2:0];
		if (n == `REQ_EXT_ZERO) lv = pa[`EXT_ZERO_LSB +: 3];
		if (n == `REQ_CAPTURE_ONE) lv = pa[`CAPTURE_ONE_LSB +: 3];
		if (n == `REQ_COMPARE_ONE) lv = pa[`COMPARE_ONE_LSB +: 3];
		if (n == `REQ_TIMER_ONE) lv = pa[`TIMER_ONE_LSB +: 3];
		return lv;
	endfunction

	logic [NUM_REQ*3-1:0] eff_levels;

	genvar g;
	generate
		for (g = 0; g < NUM_REQ; g++) begin : g_lvl
			// level zero or no request yields zero
			assign eff_levels[g*3 +: 3] = pending[g] ?
				level_of(g, priority_control_a, prio_b) : 3'h0;
		end
	endgenerate

	logic win_found;
	req_num_t win_req;
	level_t win_level;

	irq_arbiter #(
		.NUM_REQ(NUM_REQ)
	) u_arb (
		.i_levels(eff_levels),
		.o_found(win_found),
		.o_req(win_req),
		.o_level(win_level)
	);

	////////////////////////////////////////////////////////////////
	// delivery to core

	deliver_state_t next_state;
	logic [23:0] next_addr;

	// only nonzero levels reach the core
	always_comb begin
		next_state = state;
		unique case (state)
			st_idle: begin
				if (enable && win_found) next_state = st_present;
			end
			st_present: begin
				next_state = st_wait_ack;
			end
			st_wait_ack: begin
				if (i_vector_ack) next_state = st_idle;
			end
			default: next_state = st_idle;
		endcase
	end

	// table base plus twice the number
	always_comb begin
		next_addr = (i_alt_table_sel ? `ALTERNATE_BASE : `PRIMARY_BASE)
			+ {16'h0000, win_req, 1'b0};
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state <= st_idle;
		end else begin
			state <= next_state;
		end
	end

	// vector is frozen while presented so the core sees a stable word
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_vector_valid <= 1'b0;
			o_vector_addr <= 24'h000000;
			o_vector_num <= 8'h00;
			o_vector_level <= 3'h0;
		end else if (state == st_idle && enable && win_found) begin
			o_vector_valid <= 1'b1;
			o_vector_addr <= next_addr;
			o_vector_num <= {1'b0, win_req} + `VECTOR_OFFSET;
			o_vector_level <= win_level;
		end else if (state == st_wait_ack && i_vector_ack) begin
			o_vector_valid <= 1'b0;
		end
	end

	always_comb begin
		ack_clear = '0;
		if (state == st_wait_ack && i_vector_ack) begin
			ack_clear[o_vector_num[6:0] - 7'h08] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// status, interrupt, read port

	logic status_rd_clr;
	assign status_rd_clr = i_rd && i_addr == `ADDR_STATUS;

	// bit0 vector presented, bit1 vector acknowledged; set wins
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			status <= 16'h0000;
		end else begin
			status <= (status_rd_clr ? 16'h0000 : status) |
				{14'h0000, state == st_wait_ack && i_vector_ack,
				state == st_idle && enable && win_found};
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status & mask);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			unique case (i_addr)
				`ADDR_PRIO_A: o_rdata <= priority_control_a;
				`ADDR_PRIO_B: o_rdata <= prio_b;
				`ADDR_STATUS: o_rdata <= status;
				`ADDR_MASK: o_rdata <= mask;
				`ADDR_CTRL: o_rdata <= {15'h0000, enable};
				`ADDR_VECTOR: o_rdata <= {o_vector_valid, 4'h0,
					o_vector_level, o_vector_num};
				`ADDR_BASE_LO: o_rdata <= o_vector_addr[15:0];
				default: o_rdata <= 16'h0000;
			endcase
		end else begin
			o_rdata <= 16'h0000;
		end
	end
endmodule // vectored_interrupt_priority_unit

// >>> dv/vectored_interrupt_priority_unit_asserts.sv
// port checker for the vectored interrupt unit
// assumes a bind onto the top module, one clock domain
`timescale 1ns/1ps
module irq_unit_checker #(
	parameter int NUM_REQ = 118
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic i_alt_table_sel,
	input wire logic i_vector_ack,
	input wire logic o_vector_valid,
	input wire logic [23:0] o_vector_addr,
	input wire logic [7:0] o_vector_num,
	input wire logic [2:0] o_vector_level
);
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////////
	// second valid cycle onward: the unit is waiting for the core
	sequence s_held;
		o_vector_valid && $past(o_vector_valid);
	endsequence
	sequence s_taken;
		s_held ##0 i_vector_ack;
	endsequence
	a_level_nonzero: assert property (
		o_vector_valid |-> o_vector_level != 3'h0)
		else $error("zero level presented");
	a_num_legal: assert property (
		o_vector_valid |-> o_vector_num < 8'(NUM_REQ + 8)
		&& o_vector_num != 8'h0c)
		else $error("illegal vector number");
	a_addr_map: assert property (
		o_vector_valid |-> (o_vector_addr - {15'h0, o_vector_num, 1'b0})
		inside {24'h000004, 24'h000104})
		else $error("vector address off its number");
	a_alt_pick: assert property (
		$rose(o_vector_valid) |->
		o_vector_addr[8] == $past(i_alt_table_sel))
		else $error("wrong vector table");
	a_vector_hold: assert property (
		s_held |-> $stable(o_vector_addr) && $stable(o_vector_num)
		&& $stable(o_vector_level))
		else $error("vector changed while presented");
	a_ack_release: assert property (
		s_taken |=> !o_vector_valid)
		else $error("vector kept after ack");
	a_early_ack: assert property (
		$rose(o_vector_valid) && i_vector_ack |=> o_vector_valid)
		else $error("first-cycle ack accepted");
	// read data only in the cycle after a read strobe
	a_rdata_idle: assert property (
		!$past(i_rd) |-> o_rdata == 16'h0)
		else $error("read data outside its cycle");
endmodule // irq_unit_checker

bind vectored_interrupt_priority_unit irq_unit_checker #(
	.NUM_REQ(NUM_REQ)
) u_irq_unit_checker (
	.i_clk_sys(i_clk_sys),
	.i_rst(i_rst),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.i_alt_table_sel(i_alt_table_sel),
	.i_vector_ack(i_vector_ack),
	.o_vector_valid(o_vector_valid),
	.o_vector_addr(o_vector_addr),
	.o_vector_num(o_vector_num),
	.o_vector_level(o_vector_level)
);

// >>> dv/core_fetch_model.sv
// core side model: acknowledges a presented vector after a delay
// assumes the unit ignores ack in the first valid cycle
`timescale 1ns/1ps
module core_fetch_model (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_vector_valid,
	input wire logic [3:0] i_delay,
	input wire logic i_eager,
	output logic o_vector_ack
);
	logic [3:0] wait_cnt;
	logic ack_pulse;
	////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || !i_vector_valid || ack_pulse)
			wait_cnt <= 4'h0;
		else
			wait_cnt <= wait_cnt + 4'h1;
	end
	// one pulse per vector; eager holds ack up like a careless core
	always_ff @(posedge i_clk_sys) begin
		ack_pulse <= !i_rst && i_vector_valid && !ack_pulse
			&& wait_cnt == i_delay;
	end
	assign o_vector_ack = ack_pulse | i_eager;
endmodule // core_fetch_model

// >>> dv/tb_vectored_interrupt_priority_unit.sv
// self-checking bench for the vectored interrupt unit
// assumes the core model answers and the checker is bound
`timescale 1ns/1ps
module tb_vectored_interrupt_priority_unit;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic alt = 1'b0;
	logic [34:0] src = '0;
	logic [3:0] delay = 4'h1;
	logic eager = 1'b0;
	logic ack, valid, o_irq;
	logic [15:0] o_rdata;
	logic [23:0] addr;
	logic [7:0] num;
	logic [2:0] lvl;
	int errors = 0;
	int compares = 0;
	// request number for each bit of src
	logic [6:0] exp_req [35] = '{7'h00, 7'h14, 7'h1d, 7'h01, 7'h05,
		7'h02, 7'h06, 7'h03, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c,
		7'h41, 7'h0d, 7'h6e, 7'h6f, 7'h70, 7'h71, 7'h72, 7'h73, 7'h74,
		7'h10, 7'h11, 7'h12, 7'h67, 7'h68, 7'h69, 7'h13, 7'h39, 7'h5e,
		7'h5f, 7'h60, 7'h61};
	always #2 i_clk_sys = ~i_clk_sys;
	vectored_interrupt_priority_unit u_vectored_interrupt_priority_unit (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_ext_irq_zero(src[0]), .i_ext_irq_one(src[1]),
		.i_ext_irq_two(src[2]), .i_capture_one(src[3]),
		.i_capture_two(src[4]), .i_compare_one(src[5]),
		.i_compare_two(src[6]), .i_timer_one_event(src[7]),
		.i_timer_two_event(src[8]), .i_timer_three_event(src[9]),
		.i_serial_periph_fault(src[10]), .i_serial_periph_done(src[11]),
		.i_async_receive_event(src[12]), .i_async_transmit_event(src[13]),
		.i_async_error_event(src[14]), .i_conv_group_done(src[15]),
		.i_conv_pair_done(src[22:16]), .i_twowire_slave_event(src[23]),
		.i_twowire_master_event(src[24]), .i_comparator_event(src[28:25]),
		.i_change_notify_event(src[29]), .i_special_event_match(src[30]),
		.i_pwm_event(src[34:31]), .i_alt_table_sel(alt),
		.i_vector_ack(ack), .o_vector_valid(valid), .o_vector_addr(addr),
		.o_vector_num(num), .o_vector_level(lvl), .o_irq(o_irq));
	core_fetch_model u_core_fetch_model (.i_clk_sys(i_clk_sys),
		.i_rst(i_rst), .i_vector_valid(valid), .i_delay(delay),
		.i_eager(eager), .o_vector_ack(ack));
	////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		chk(24'(o_rdata), 24'(d));
	endtask
	task automatic pulse(input logic [34:0] m);
		@(posedge i_clk_sys);
		src <= m;
		@(posedge i_clk_sys);
		src <= '0;
	endtask
	task automatic wait_v(input logic v);
		int k;
		k = 0;
		while (valid !== v) begin
			tick(1);
			k++;
			if (k > 40) begin
				errors++;
				finish_test();
			end
		end
	endtask
	task automatic expect_vec(input logic [6:0] n, input logic [2:0] l);
		wait_v(1'b1);
		chk(24'(num), 24'(n) + 24'h8);
		chk(addr, (alt ? 24'h000114 : 24'h000014) + 24'({n, 1'b0}));
		chk(24'(lvl), 24'(l));
		wait_v(1'b0);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		rdc(4'h0, 16'h4444);
		rdc(4'h1, 16'h0004);
		rdc(4'hf, 16'h0000);
		for (int i = 0; i < 35; i++) begin
			@(posedge i_clk_sys);
			alt <= i[0];
			pulse(35'h1 << i);
			expect_vec(exp_req[i], 3'h4);
		end
		// core holding ack high: first cycle ignored, second taken
		eager <= 1'b1;
		pulse(35'h1 << 8);
		wait_v(1'b1);
		tick(1);
		chk(24'(valid), 24'h1);
		tick(1);
		chk(24'(valid), 24'h0);
		eager <= 1'b0;
		wr(4'h0, 16'hffff);
		rdc(4'h0, 16'h7777);
		wr(4'h0, 16'h7022);
		delay <= 4'h6;
		pulse(35'h000a9);
		expect_vec(7'h03, 3'h7);
		expect_vec(7'h00, 3'h2);
		expect_vec(7'h01, 3'h2);
		tick(10);
		chk(24'(valid), 24'h0);
		chk(24'(o_irq), 24'h0);
		wr(4'h3, 16'h0001);
		tick(2);
		chk(24'(o_irq), 24'h1);
		rdc(4'h2, 16'h0003);
		tick(2);
		chk(24'(o_irq), 24'h0);
		rdc(4'h2, 16'h0000);
		// reset in mid-run drops the standing vector, restores levels
		pulse(35'h1 << 7);
		wait_v(1'b1);
		@(posedge i_clk_sys);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		#1;
		chk(24'(valid), 24'h0);
		chk(24'(o_irq), 24'h0);
		rdc(4'h0, 16'h4444);
		// delivery held off while disabled, resumes once enabled
		wr(4'h4, 16'h0000);
		pulse(35'h1);
		tick(4);
		chk(24'(valid), 24'h0);
		rdc(4'h4, 16'h0000);
		wr(4'h4, 16'h0001);
		expect_vec(7'h00, 3'h4);
		// shared level at zero disables every other source
		wr(4'h1, 16'h0000);
		pulse(35'h1 << 8);
		tick(4);
		chk(24'(valid), 24'h0);
		finish_test();
	end
endmodule // tb_vectored_interrupt_priority_unit
